// >>> fms_map.svh
// Constants of the two-wire memory slave: widths, codes, counts
`ifndef FMS_MAP_SVH
`define FMS_MAP_SVH

`define FMS_ADDR_W    11
`define FMS_MEM_DEPTH 2048
`define FMS_UPPER_W   3
// Device type code; value is arbitrary, not any real part's
`define FMS_TYPE_CODE 4'h6
`define FMS_TYPE_MSB  7
`define FMS_TYPE_LSB  4
`define FMS_UPPER_MSB 3
`define FMS_UPPER_LSB 1
`define FMS_RW_BIT    0
`define FMS_LAST_BIT  3'h7
`define FMS_CLR_CYC   2'h2
`define FMS_ADDR_ONE  11'h001

`endif

// >>> fms_pkg.sv
// Types shared by the two-wire memory slave
package fms_pkg;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_DEVADR = 4'b0001,
    ST_ACKDEV = 4'b0010,
    ST_RXLOW  = 4'b0011,
    ST_ACKLOW = 4'b0100,
    ST_RXDAT  = 4'b0101,
    ST_ACKDAT = 4'b0110,
    ST_TX     = 4'b0111,
    ST_RACK   = 4'b1000
  } fms_state_e;

  typedef logic [10:0] fms_addr_t;
  typedef logic [7:0]  fms_byte_t;

endpackage

// >>> fms_slave.sv
// Two-wire serial slave with 2,048 x 8 byte-writable storage
`timescale 1ns/1ps
`include "fms_map.svh"

module fms_slave (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic scl,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  input  wire logic wp,
  output logic      bus_active
);

  // ****************************************
  // System clock side: pin sync, stop, clear
  // ****************************************
  logic       scl_1_q, scl_2_q, scl_3_q, scl_s_q, scl_p_q;
  logic [1:0] scl_h_q;
  logic       sda_1_q, sda_2_q, sda_3_q, sda_s_q, sda_p_q;
  logic       wp_1_q, wp_2_q, wp_3_q, wp_s_q;
  logic       start_det, stop_det;
  logic [1:0] clr_cnt_q;
  logic       link_clr_q;
  logic       bus_active_q;
  logic       sda_o_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_1_q <= 1'b1;
      scl_2_q <= 1'b1;
      scl_3_q <= 1'b1;
      scl_h_q <= 2'h3;
      sda_1_q <= 1'b1;
      sda_2_q <= 1'b1;
      sda_3_q <= 1'b1;
    end else begin
      scl_1_q <= scl;
      scl_2_q <= scl_1_q;
      scl_3_q <= scl_2_q;
      scl_h_q <= {scl_h_q[0], scl_3_q};
      sda_1_q <= sda_i;
      sda_2_q <= sda_1_q;
      sda_3_q <= sda_2_q;
    end
  end

  // Pad pull-down makes an open pin low; reset value low too
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wp_1_q <= 1'b0;
      wp_2_q <= 1'b0;
      wp_3_q <= 1'b0;
      wp_s_q <= 1'b0;
    end else begin
      wp_1_q <= wp;
      wp_2_q <= wp_1_q;
      wp_3_q <= wp_2_q;
      if (wp_2_q == wp_3_q) begin
        wp_s_q <= wp_3_q;
      end
    end
  end

  // A change counts once the last two stages agree
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_s_q <= 1'b1;
      sda_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      if (scl_2_q == scl_3_q) begin
        scl_s_q <= scl_3_q;
      end
      if (sda_2_q == sda_3_q) begin
        sda_s_q <= sda_3_q;
      end
      scl_p_q <= scl_s_q;
      sda_p_q <= sda_s_q;
    end
  end

  // Raw SCL high round the SDA change; a low the filter hid is a data bit
  assign start_det = scl_p_q & scl_s_q & (&scl_h_q) & scl_3_q & sda_p_q & ~sda_s_q;
  assign stop_det  = scl_p_q & scl_s_q & (&scl_h_q) & scl_3_q & ~sda_p_q & sda_s_q;

  // Stop holds the link logic cleared a few cycles; SCL rests high
  // then, so the release lands with no link edge pending.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      clr_cnt_q  <= `FMS_CLR_CYC;
      link_clr_q <= 1'b1;
    end else if (stop_det) begin
      clr_cnt_q  <= `FMS_CLR_CYC;
      link_clr_q <= 1'b1;
    end else begin
      link_clr_q <= (clr_cnt_q != 2'h0);
      if (clr_cnt_q != 2'h0) begin
        clr_cnt_q <= clr_cnt_q - 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_active_q <= 1'b0;
    end else if (start_det) begin
      bus_active_q <= 1'b1;
    end else if (stop_det) begin
      bus_active_q <= 1'b0;
    end
  end

  // Open drain: data level is always low, only the enable moves
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sda_o_q <= 1'b0;
    end else begin
      sda_o_q <= 1'b0;
    end
  end

  assign sda_o      = sda_o_q;
  assign bus_active = bus_active_q;

  // ****************************************
  // Link side: sampling on SCL rise
  // ****************************************
  logic      rise_smp_q;
  fms_pkg::fms_byte_t sh_q;
  logic      wp_m_q, wp_l_q;

  always_ff @(posedge scl or posedge link_clr_q) begin
    if (link_clr_q) begin
      rise_smp_q <= 1'b1;
      sh_q       <= 8'h00;
    end else begin
      rise_smp_q <= sda_i;
      sh_q       <= {sh_q[6:0], sda_i};
    end
  end

  always_ff @(posedge scl or posedge link_clr_q) begin
    if (link_clr_q) begin
      wp_m_q <= 1'b0;
      wp_l_q <= 1'b0;
    end else begin
      wp_m_q <= wp_s_q;
      wp_l_q <= wp_m_q;
    end
  end

  // ****************************************
  // Link side: state machine on SCL fall
  // ****************************************
  fms_pkg::fms_state_e state_q;
  logic [2:0]          cnt_q;
  logic [2:0]          upper_q;
  fms_pkg::fms_addr_t  buf_q;
  logic                fresh_q;
  fms_pkg::fms_byte_t  tx_q;
  logic                sda_oe_q;
  logic                start_scl;
  logic                last_bit;
  logic                type_ok;
  fms_pkg::fms_addr_t  cur_addr;
  logic                mem_we;
  fms_pkg::fms_byte_t  mem_rd;
  fms_pkg::fms_byte_t  mem_q [`FMS_MEM_DEPTH];

  // SDA moved while SCL was high and fell: a start
  assign start_scl = rise_smp_q & ~sda_i;
  assign last_bit  = (cnt_q == `FMS_LAST_BIT);
  assign type_ok   = (sh_q[`FMS_TYPE_MSB:`FMS_TYPE_LSB] == `FMS_TYPE_CODE);
  // A freshly loaded address is used as is, otherwise the next one
  assign cur_addr  = fresh_q ? buf_q : buf_q + `FMS_ADDR_ONE;
  assign mem_we    = (state_q == fms_pkg::ST_RXDAT) && last_bit && !start_scl
                     && !wp_l_q;
  assign mem_rd    = mem_q[cur_addr];

  always_ff @(negedge scl or posedge link_clr_q) begin
    if (link_clr_q) begin
      state_q  <= fms_pkg::ST_IDLE;
      cnt_q    <= 3'h0;
      sda_oe_q <= 1'b0;
      tx_q     <= 8'h00;
      upper_q  <= 3'h0;
    end else if (start_scl) begin
      state_q  <= fms_pkg::ST_DEVADR;
      cnt_q    <= 3'h0;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        fms_pkg::ST_DEVADR: begin
          cnt_q <= cnt_q + 3'h1;
          if (last_bit) begin
            if (type_ok) begin
              upper_q  <= sh_q[`FMS_UPPER_MSB:`FMS_UPPER_LSB];
              sda_oe_q <= 1'b1;
              state_q  <= fms_pkg::ST_ACKDEV;
            end else begin
              state_q  <= fms_pkg::ST_IDLE;
            end
          end
        end
        fms_pkg::ST_ACKDEV: begin
          cnt_q <= 3'h0;
          // Ack clock shifted one more bit in: direction sits one up
          if (sh_q[`FMS_RW_BIT + 1]) begin
            tx_q     <= {mem_rd[6:0], 1'b0};
            sda_oe_q <= ~mem_rd[7];
            state_q  <= fms_pkg::ST_TX;
          end else begin
            sda_oe_q <= 1'b0;
            state_q  <= fms_pkg::ST_RXLOW;
          end
        end
        fms_pkg::ST_RXLOW: begin
          cnt_q <= cnt_q + 3'h1;
          if (last_bit) begin
            sda_oe_q <= 1'b1;
            state_q  <= fms_pkg::ST_ACKLOW;
          end
        end
        fms_pkg::ST_ACKLOW, fms_pkg::ST_ACKDAT: begin
          cnt_q    <= 3'h0;
          sda_oe_q <= 1'b0;
          state_q  <= fms_pkg::ST_RXDAT;
        end
        fms_pkg::ST_RXDAT: begin
          cnt_q <= cnt_q + 3'h1;
          if (last_bit) begin
            sda_oe_q <= 1'b1;
            state_q  <= fms_pkg::ST_ACKDAT;
          end
        end
        fms_pkg::ST_TX: begin
          cnt_q <= cnt_q + 3'h1;
          if (last_bit) begin
            sda_oe_q <= 1'b0;
            state_q  <= fms_pkg::ST_RACK;
          end else begin
            sda_oe_q <= ~tx_q[7];
            tx_q     <= {tx_q[6:0], 1'b0};
          end
        end
        fms_pkg::ST_RACK: begin
          cnt_q <= 3'h0;
          if (!sh_q[0]) begin
            tx_q     <= {mem_rd[6:0], 1'b0};
            sda_oe_q <= ~mem_rd[7];
            state_q  <= fms_pkg::ST_TX;
          end else begin
            sda_oe_q <= 1'b0;
            state_q  <= fms_pkg::ST_IDLE;
          end
        end
        default: begin
          cnt_q    <= 3'h0;
          sda_oe_q <= 1'b0;
          state_q  <= fms_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Address buffer survives the clear: it is the last accessed
  // address between transfers; undefined until first loaded.
  always_ff @(negedge scl) begin
    if (!link_clr_q && !start_scl) begin
      if (state_q == fms_pkg::ST_RXLOW && last_bit) begin
        buf_q   <= {upper_q, sh_q};
        fresh_q <= 1'b1;
      end else if (state_q == fms_pkg::ST_DEVADR && last_bit && type_ok
                   && sh_q[`FMS_RW_BIT]) begin
        buf_q <= {sh_q[`FMS_UPPER_MSB:`FMS_UPPER_LSB], buf_q[7:0]};
      end else if ((state_q == fms_pkg::ST_RXDAT && last_bit)
                   || (state_q == fms_pkg::ST_ACKDEV && sh_q[`FMS_RW_BIT + 1])
                   || (state_q == fms_pkg::ST_RACK && !sh_q[0])) begin
        buf_q   <= cur_addr;
        fresh_q <= 1'b0;
      end
    end
  end

  // Storage has no reset: contents are meant to persist
  always_ff @(negedge scl) begin
    if (mem_we) begin
      mem_q[cur_addr] <= sh_q;
    end
  end

  assign sda_oe = sda_oe_q;

  // ****************************************
  // Checks
  // ****************************************
  property p_ack_dev;
    @(negedge scl) disable iff (link_clr_q)
    (state_q == fms_pkg::ST_DEVADR && last_bit && type_ok && !start_scl)
      |=> (sda_oe_q && state_q == fms_pkg::ST_ACKDEV);
  endproperty
  a_ack_dev: assert property (p_ack_dev) else $error("device word not acknowledged");

  property p_bad_type;
    @(negedge scl) disable iff (link_clr_q)
    (state_q == fms_pkg::ST_DEVADR && last_bit && !type_ok && !start_scl)
      |=> (!sda_oe_q && state_q == fms_pkg::ST_IDLE);
  endproperty
  a_bad_type: assert property (p_bad_type) else $error("foreign type code answered");

  property p_write_ok;
    @(negedge scl) disable iff (link_clr_q)
    (state_q == fms_pkg::ST_RXDAT && last_bit && !start_scl && !wp_l_q)
      |=> (mem_q[buf_q] == $past(sh_q));
  endproperty
  a_write_ok: assert property (p_write_ok) else $error("byte not stored");

  property p_write_prot;
    @(negedge scl) disable iff (link_clr_q)
    (state_q == fms_pkg::ST_RXDAT && last_bit && !start_scl && wp_l_q)
      |=> (mem_q[buf_q] == $past(mem_rd));
  endproperty
  a_write_prot: assert property (p_write_prot) else $error("protected byte changed");

  property p_wrap;
    @(negedge scl) disable iff (link_clr_q)
    (state_q == fms_pkg::ST_RXDAT && last_bit && !start_scl && !fresh_q)
      |=> (buf_q == fms_pkg::fms_addr_t'($past(buf_q) + `FMS_ADDR_ONE));
  endproperty
  a_wrap: assert property (p_wrap) else $error("address did not advance");

  property p_release;
    @(negedge scl) disable iff (link_clr_q)
    (state_q == fms_pkg::ST_TX && last_bit && !start_scl)
      |=> (!sda_oe_q && state_q == fms_pkg::ST_RACK);
  endproperty
  a_release: assert property (p_release) else $error("SDA held on ack clock");

  property p_nack;
    @(negedge scl) disable iff (link_clr_q)
    (state_q == fms_pkg::ST_RACK && sh_q[0] && !start_scl)
      |=> (!sda_oe_q && state_q == fms_pkg::ST_IDLE) ##1 !sda_oe_q;
  endproperty
  a_nack: assert property (p_nack) else $error("drive after no-ack");

  property p_restart;
    @(negedge scl) disable iff (link_clr_q)
    start_scl |=> (state_q == fms_pkg::ST_DEVADR && cnt_q == 3'h0 && !sda_oe_q);
  endproperty
  a_restart: assert property (p_restart) else $error("start not decoded");

  property p_stop_clear;
    @(posedge clk) disable iff (!reset_n)
    stop_det |=> link_clr_q [*3] ##1 !link_clr_q;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stop did not clear link");

  property p_open_drain;
    @(posedge clk) disable iff (!reset_n)
    $rose(bus_active_q) |-> !sda_o_q;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("SDA driven high");

endmodule

// >>> fms_host.sv
// Behavioural bus master that drives the two-wire slave
`timescale 1ns/1ps

module fms_host (
  output logic       scl,
  output logic       sda_rel,
  input  wire logic  sda,
  output logic [7:0] res
);
  localparam int Q = 40;
  // Start and stop edges held several system clocks for the slave's filter
  localparam int H = 200;
  event got;

  // Clock stands high between frames; only this side drives it
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
    res = 8'h00;
  end

  // One clock: data set mid-low, sampled mid-high
  task automatic tick(input logic b, output logic s);
    #Q;
    sda_rel = b;
    #Q;
    scl = 1'b1;
    #Q;
    s = sda;
    #Q;
    scl = 1'b0;
  endtask

  // Also serves as repeated start from a low clock
  task automatic start();
    #Q;
    sda_rel = 1'b1;
    #Q;
    scl = 1'b1;
    #H;
    sda_rel = 1'b0;
    #H;
    scl = 1'b0;
  endtask

  // Idle kept long enough for the slave's clear after a stop
  task automatic stop();
    #Q;
    sda_rel = 1'b0;
    #Q;
    scl = 1'b1;
    #H;
    sda_rel = 1'b1;
    #400;
  endtask

  task automatic put(input logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) tick(v[i], s);
    tick(1'b1, s);
    res = {7'h00, s};
    -> got;
  endtask

  task automatic get(input logic nack);
    logic [7:0] v;
    logic       s;
    for (int i = 7; i >= 0; i--) begin
      tick(1'b1, s);
      v[i] = s;
    end
    tick(nack, s);
    res = v;
    -> got;
  endtask
endmodule

// >>> fms_slave_bench.sv
// Self-checking bench for the two-wire memory slave
`timescale 1ns/1ps
`include "fms_map.svh"

module fms_slave_bench;
  logic       clk;
  logic       reset_n;
  logic       wp;
  logic       scl;
  logic       sda_rel;
  logic       sda_o;
  logic       sda_oe;
  logic       bus_active;
  logic [7:0] res;
  wire logic  sda_line;
  logic [7:0] shadow [2048];
  logic [7:0] q [$];
  int         err_count;
  int         checked;

  // Open drain with pull-up: low when either side pulls
  assign sda_line = sda_rel & ~(sda_oe & ~sda_o);

  fms_slave fms_slave_inst (
    .clk        (clk),
    .reset_n    (reset_n),
    .scl        (scl),
    .sda_i      (sda_line),
    .sda_o      (sda_o),
    .sda_oe     (sda_oe),
    .wp         (wp),
    .bus_active (bus_active)
  );

  fms_host fms_host_inst (
    .scl     (scl),
    .sda_rel (sda_rel),
    .sda     (sda_line),
    .res     (res)
  );

  always #25 clk = ~clk;

  // ****************************************
  // Checking
  // ****************************************
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Empty queue yields an unknown note, which never matches
  always @(fms_host_inst.got) begin
    chk("link result", res, q.size() ? q.pop_front() : 8'hxx);
  end

  // ****************************************
  // Transfers
  // ****************************************
  task automatic word(input logic [2:0] up, input logic rw, input logic [3:0] ty);
    fms_host_inst.start();
    q.push_back({7'h00, ty != `FMS_TYPE_CODE});
    fms_host_inst.put({ty, up, rw});
  endtask

  task automatic wr(input logic [10:0] a, input int n);
    logic [7:0] d;
    word(a[10:8], 1'b0, `FMS_TYPE_CODE);
    chk("bus in frame", {7'h00, bus_active}, 8'h01);
    q.push_back(8'h00);
    fms_host_inst.put(a[7:0]);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      if (wp === 1'b0) shadow[a] = d;
      a = a + `FMS_ADDR_ONE;
      q.push_back(8'h00);
      fms_host_inst.put(d);
    end
    fms_host_inst.stop();
  endtask

  // Current read passes the address it expects to see first
  task automatic rd(input logic [10:0] a, input logic cur, input int n);
    if (!cur) begin
      word(a[10:8], 1'b0, `FMS_TYPE_CODE);
      q.push_back(8'h00);
      fms_host_inst.put(a[7:0]);
    end
    word(a[10:8], 1'b1, `FMS_TYPE_CODE);
    for (int i = 0; i < n; i++) begin
      q.push_back(shadow[a]);
      a = a + `FMS_ADDR_ONE;
      fms_host_inst.get(i == n - 1);
    end
    fms_host_inst.stop();
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    wp = 1'b0;
    err_count = 0;
    checked = 0;
    void'($urandom(65));
    repeat (5) @(negedge clk);
    chk("oe in reset", {7'h00, sda_oe}, 8'h00);
    reset_n = 1'b1;
    repeat (6) @(negedge clk);
    wr(11'h7fe, 3);
    chk("bus after stop", {7'h00, bus_active}, 8'h00);
    chk("sda data", {7'h00, sda_o}, 8'h00);
    rd(11'h7fe, 1'b0, 3);
    wr(11'h210, 2);
    wr(11'h511, 1);
    rd(11'h210, 1'b0, 1);
    rd(11'h511, 1'b1, 1);
    @(negedge clk);
    wp = 1'b1;
    wr(11'h210, 2);
    rd(11'h210, 1'b0, 2);
    @(negedge clk);
    wp = 1'b0;
    for (int t = 0; t < 16; t++) begin
      word(3'(t), 1'b0, 4'(t));
      fms_host_inst.stop();
    end
    rd(11'h7ff, 1'b0, 2);
    chk("queue left", 8'(q.size()), 8'h00);
    test_done();
  end

  // Expected run is near 110 us; the 300 us limit, under three times that, cuts a hang
  initial begin
    #300000;
    err_count++;
    test_done();
  end
endmodule
